/* mpfcu_command_unit.sv */
`timescale 1ns/100ps
`include "mpfcu_map.svh"

// ****************************************
// One pulse channel
// ****************************************
module mpfcu_pulse_channel
	import mpfcu_pkg::*;
(
	input wire logic clk,
	input wire logic reset_n,
	input wire logic start,
	input wire logic stop,
	input mpfcu_pulse_cfg_t cfg,
	output logic running,
	output logic pulse_out
);
	logic run_ff, nxt_run;
	logic out_ff, nxt_out;
	logic forever_ff, nxt_forever;
	mpfcu_phase_t phase_ff, nxt_phase;
	logic [15:0] units_ff, nxt_units;
	logic [15:0] left_ff, nxt_left;
	logic [12:0] pre_ff, nxt_pre;
	logic unit_done;

	// per-channel unit prescaler
	// Restarted by each enable, so the first phase is never cut short
	assign unit_done = (pre_ff == 13'(`MPFCU_UNIT_CYCLES - 1));

	// ****************************************
	// Phase and burst counting
	// ****************************************
	always_comb begin
		nxt_run = run_ff;
		nxt_out = out_ff;
		nxt_forever = forever_ff;
		nxt_phase = phase_ff;
		nxt_units = units_ff;
		nxt_left = left_ff;
		nxt_pre = (run_ff && !unit_done) ? pre_ff + 13'h0001 : 13'h0000;
		if (start) begin
			nxt_run = 1'b1;
			nxt_pre = 13'h0000;
			nxt_forever = (cfg.burst == `MPFCU_RST_WORD);
			nxt_left = cfg.burst;
			nxt_phase = MPFCU_PHASE_HIGH;
			nxt_units = `MPFCU_RST_WORD;
			nxt_out = 1'b1;
		end else if (stop) begin
			nxt_run = 1'b0;
			nxt_out = 1'b0;
		end else if (run_ff && unit_done) begin
			// periods counted in 100 us units
			case (phase_ff)
				MPFCU_PHASE_HIGH: begin
					if (units_ff + 16'h0001 >= cfg.high_period) begin
						nxt_phase = MPFCU_PHASE_LOW;
						nxt_units = `MPFCU_RST_WORD;
						nxt_out = 1'b0;
					end else begin
						nxt_units = units_ff + 16'h0001;
					end
				end
				default: begin
					if (units_ff + 16'h0001 >= cfg.low_period) begin
						nxt_units = `MPFCU_RST_WORD;
						if (!forever_ff && left_ff <= 16'h0001) begin
							nxt_run = 1'b0;
							nxt_out = 1'b0;
						end else begin
							nxt_left = forever_ff ? left_ff : left_ff - 16'h0001;
							nxt_phase = MPFCU_PHASE_HIGH;
							nxt_out = 1'b1;
						end
					end else begin
						nxt_units = units_ff + 16'h0001;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			run_ff <= 1'b0;
			out_ff <= 1'b0;
			forever_ff <= 1'b0;
			phase_ff <= MPFCU_PHASE_HIGH;
			units_ff <= `MPFCU_RST_WORD;
			left_ff <= `MPFCU_RST_WORD;
			pre_ff <= 13'h0000;
		end else begin
			run_ff <= nxt_run;
			out_ff <= nxt_out;
			forever_ff <= nxt_forever;
			phase_ff <= nxt_phase;
			units_ff <= nxt_units;
			left_ff <= nxt_left;
			pre_ff <= nxt_pre;
		end
	end

	assign running = run_ff;
	assign pulse_out = out_ff;
endmodule : mpfcu_pulse_channel

// ****************************************
// Mailbox command interpreter
// ****************************************
module mpfcu_command_unit
	import mpfcu_pkg::*;
#(
	parameter logic [15:0] FIRMWARE_VERSION = 16'h0100, // Arbitrary value
	parameter logic [15:0] HARDWARE_VERSION = 16'h0100 // Arbitrary value
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [5:0] bus_addr,
	input wire logic bus_write,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	input wire logic [7:0] isolated_input,
	output logic [7:0] filter_enable,
	output logic pulse_channel_a,
	output logic pulse_channel_b
);
	localparam int UNIT_CYCLES = `MPFCU_UNIT_CYCLES;

	logic [7:0] param_low_ff, nxt_param_low;
	logic [7:0] param_high_ff, nxt_param_high;
	logic [7:0] reserved_ff, nxt_reserved;
	mpfcu_mailbox_in_t mbox_ff, nxt_mbox;
	mpfcu_pulse_cfg_t cfg_a_ff, nxt_cfg_a;
	mpfcu_pulse_cfg_t cfg_b_ff, nxt_cfg_b;
	logic [7:0] filter_ff, nxt_filter;
	logic [12:0] tick_cnt_ff, nxt_tick_cnt;
	logic tick;
	logic cmd_wr;
	logic [7:0] cmd;
	logic [15:0] param;
	logic start_a, start_b, stop_a, stop_b;
	logic run_a, run_b;
	logic [15:0] rb_value;
	logic [7:0] rdata_ff, nxt_rdata;

	assign cmd_wr = bus_write && (bus_addr == `MPFCU_ADDR_OUT_COMMAND);
	assign cmd = bus_wdata;
	assign param = {param_high_ff, param_low_ff};
	assign tick = (tick_cnt_ff == 13'(UNIT_CYCLES - 1));

	// ****************************************
	// Read-back selection
	// ****************************************
	always_comb begin
		rb_value = {mbox_ff.result_high, mbox_ff.result_low};
		if (param_low_ff == `MPFCU_CMD_FILTER_ENABLE) begin
			rb_value = {mbox_ff.result_high, filter_ff};
		end else if (param_low_ff == `MPFCU_CMD_A_HIGH) begin
			rb_value = cfg_a_ff.high_period;
		end else if (param_low_ff == `MPFCU_CMD_A_LOW) begin
			rb_value = cfg_a_ff.low_period;
		end else if (param_low_ff == `MPFCU_CMD_B_HIGH) begin
			rb_value = cfg_b_ff.high_period;
		end else if (param_low_ff == `MPFCU_CMD_B_LOW) begin
			rb_value = cfg_b_ff.low_period;
		end else if (param_low_ff == `MPFCU_CMD_A_BURST) begin
			rb_value = cfg_a_ff.burst;
		end else if (param_low_ff == `MPFCU_CMD_B_BURST) begin
			rb_value = cfg_b_ff.burst;
		end else if (param_low_ff == `MPFCU_CMD_PULSE_ENABLE) begin
			rb_value = {mbox_ff.result_high, 6'h00, run_b, run_a};
		end else if (param_low_ff == `MPFCU_CMD_FW_VERSION) begin
			rb_value = FIRMWARE_VERSION;
		end else if (param_low_ff == `MPFCU_CMD_HW_VERSION) begin
			rb_value = HARDWARE_VERSION;
		end
	end

	// ****************************************
	// Mailbox and command execution
	// ****************************************
	always_comb begin
		nxt_param_low = param_low_ff;
		nxt_param_high = param_high_ff;
		nxt_reserved = reserved_ff;
		nxt_mbox = mbox_ff;
		nxt_cfg_a = cfg_a_ff;
		nxt_cfg_b = cfg_b_ff;
		nxt_filter = filter_ff;
		nxt_tick_cnt = tick ? 13'h0000 : tick_cnt_ff + 13'h0001;
		start_a = 1'b0;
		start_b = 1'b0;
		stop_a = 1'b0;
		stop_b = 1'b0;
		if (tick) begin
			nxt_mbox.input_state = isolated_input;
		end
		if (bus_write && bus_addr == `MPFCU_ADDR_OUT_PARAM_LOW) begin
			nxt_param_low = bus_wdata;
		end else if (bus_write && bus_addr == `MPFCU_ADDR_OUT_PARAM_HIGH) begin
			nxt_param_high = bus_wdata;
		end else if (bus_write && bus_addr == `MPFCU_ADDR_OUT_RESERVED) begin
			nxt_reserved = bus_wdata;
		end else if (cmd_wr) begin
			nxt_mbox.echo = cmd;
			case (cmd)
				`MPFCU_CMD_READ_BACK: begin
					{nxt_mbox.result_high, nxt_mbox.result_low} = rb_value;
				end
				`MPFCU_CMD_FW_VERSION: begin
					{nxt_mbox.result_high, nxt_mbox.result_low} = FIRMWARE_VERSION;
				end
				`MPFCU_CMD_HW_VERSION: begin
					{nxt_mbox.result_high, nxt_mbox.result_low} = HARDWARE_VERSION;
				end
				`MPFCU_CMD_A_HIGH: begin
					nxt_cfg_a.high_period = param;
				end
				`MPFCU_CMD_A_LOW: begin
					nxt_cfg_a.low_period = param;
				end
				`MPFCU_CMD_B_HIGH: begin
					nxt_cfg_b.high_period = param;
				end
				`MPFCU_CMD_B_LOW: begin
					nxt_cfg_b.low_period = param;
				end
				`MPFCU_CMD_A_BURST: begin
					nxt_cfg_a.burst = param;
				end
				`MPFCU_CMD_B_BURST: begin
					nxt_cfg_b.burst = param;
				end
				`MPFCU_CMD_PULSE_ENABLE: begin
					start_a = param_low_ff[0];
					stop_a = !param_low_ff[0];
					start_b = param_low_ff[1];
					stop_b = !param_low_ff[1];
				end
				`MPFCU_CMD_FILTER_ENABLE: begin
					nxt_filter = param_low_ff;
				end
				default: begin
				end
			endcase
		end
	end

	// ****************************************
	// Register update
	// ****************************************
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			param_low_ff <= `MPFCU_RST_BYTE;
			param_high_ff <= `MPFCU_RST_BYTE;
			reserved_ff <= `MPFCU_RST_BYTE;
			mbox_ff <= '0;
			cfg_a_ff <= '0;
			cfg_b_ff <= '0;
			filter_ff <= `MPFCU_RST_BYTE;
			tick_cnt_ff <= 13'h0000;
		end else begin
			param_low_ff <= nxt_param_low;
			param_high_ff <= nxt_param_high;
			reserved_ff <= nxt_reserved;
			mbox_ff <= nxt_mbox;
			cfg_a_ff <= nxt_cfg_a;
			cfg_b_ff <= nxt_cfg_b;
			filter_ff <= nxt_filter;
			tick_cnt_ff <= nxt_tick_cnt;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	always_comb begin
		if (bus_addr == `MPFCU_ADDR_IN_RESULT_LOW) begin
			nxt_rdata = mbox_ff.result_low;
		end else if (bus_addr == `MPFCU_ADDR_IN_RESULT_HIGH) begin
			nxt_rdata = mbox_ff.result_high;
		end else if (bus_addr == `MPFCU_ADDR_IN_ECHO) begin
			nxt_rdata = mbox_ff.echo;
		end else if (bus_addr == `MPFCU_ADDR_IN_INPUT_STATE) begin
			nxt_rdata = mbox_ff.input_state;
		end else begin
			nxt_rdata = 8'h00;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rdata_ff <= `MPFCU_RST_BYTE;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// Registered read data: a byte stands one cycle after its address
	assign bus_rdata = rdata_ff;
	assign filter_enable = filter_ff;

	// ****************************************
	// Pulse channels
	// ****************************************
	mpfcu_pulse_channel u_chan_a (
		.clk(clk),
		.reset_n(reset_n),
		.start(start_a),
		.stop(stop_a),
		.cfg(cfg_a_ff),
		.running(run_a),
		.pulse_out(pulse_channel_a)
	);

	mpfcu_pulse_channel u_chan_b (
		.clk(clk),
		.reset_n(reset_n),
		.start(start_b),
		.stop(stop_b),
		.cfg(cfg_b_ff),
		.running(run_b),
		.pulse_out(pulse_channel_b)
	);
endmodule : mpfcu_command_unit

/* mpfcu_map.svh */
`ifndef MPFCU_MAP_SVH
`define MPFCU_MAP_SVH
// What this block does
// - Read-back parameter low byte selects command code
// - Read-back result lands in result bytes
// - Received command code echoed to echo byte
// - Top incoming byte shows isolated inputs
// - 0E firmware, 0F hardware 16-bit versions
// - 10-13 load high/low periods, channels A/B
// - Period equals 256 times high plus low
// - Period unit 100 us; cycle is high+low
// - 14/15 load burst counts for A/B
// - Zero burst runs forever, else exact cycles
// - 1F bits 0/1 enable channels A/B
// - On enable, check burst; self-disable when done
// - 20 sets per-input filter enable mask
// - Read-back of 20 returns filter mask
// - Input byte refreshed every 100 us
// - Echo updates only after successful receipt

// ****************************************
// Byte addresses
// ****************************************
`define MPFCU_ADDR_OUT_PARAM_LOW 6'h0c
`define MPFCU_ADDR_OUT_PARAM_HIGH 6'h0d
`define MPFCU_ADDR_OUT_COMMAND 6'h0e
`define MPFCU_ADDR_OUT_RESERVED 6'h0f
`define MPFCU_ADDR_IN_RESULT_LOW 6'h1c
`define MPFCU_ADDR_IN_RESULT_HIGH 6'h1d
`define MPFCU_ADDR_IN_ECHO 6'h1e
`define MPFCU_ADDR_IN_INPUT_STATE 6'h1f

// ****************************************
// Command codes
// ****************************************
`define MPFCU_CMD_READ_BACK 8'h07
`define MPFCU_CMD_FW_VERSION 8'h0e
`define MPFCU_CMD_HW_VERSION 8'h0f
`define MPFCU_CMD_A_HIGH 8'h10
`define MPFCU_CMD_A_LOW 8'h11
`define MPFCU_CMD_B_HIGH 8'h12
`define MPFCU_CMD_B_LOW 8'h13
`define MPFCU_CMD_A_BURST 8'h14
`define MPFCU_CMD_B_BURST 8'h15
`define MPFCU_CMD_PULSE_ENABLE 8'h1f
`define MPFCU_CMD_FILTER_ENABLE 8'h20

// ****************************************
// Reset values and timing
// ****************************************
`define MPFCU_RST_BYTE 8'h00
`define MPFCU_RST_WORD 16'h0000
`define MPFCU_CLK_HZ 50000000
`define MPFCU_UNIT_US 100
`define MPFCU_UNIT_CYCLES (`MPFCU_CLK_HZ / 1000000 * `MPFCU_UNIT_US)
`endif

/* mpfcu_pkg.sv */
package mpfcu_pkg;
	typedef struct packed {
		logic [15:0] high_period;
		logic [15:0] low_period;
		logic [15:0] burst;
	} mpfcu_pulse_cfg_t;

	typedef struct packed {
		logic [7:0] input_state;
		logic [7:0] echo;
		logic [7:0] result_high;
		logic [7:0] result_low;
	} mpfcu_mailbox_in_t;

	typedef enum logic {
		MPFCU_PHASE_HIGH,
		MPFCU_PHASE_LOW
	} mpfcu_phase_t;
endpackage : mpfcu_pkg

/* mpfcu_monitor.sv */
`timescale 1ns/100ps
// ********************
// Port checker
// ********************
module mpfcu_monitor (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [5:0] bus_addr,
	input wire logic bus_write,
	input wire logic [7:0] bus_wdata,
	input wire logic [7:0] bus_rdata,
	input wire logic [7:0] isolated_input,
	input wire logic [7:0] filter_enable,
	input wire logic pulse_channel_a,
	input wire logic pulse_channel_b
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic cmd;
	logic [7:0] param_ff;
	logic [7:0] echo_ff;
	logic [7:0] nxt_param;
	logic [7:0] nxt_echo;
	assign cmd = bus_write && bus_addr == 6'h0e;
	always_comb begin
		nxt_param = (bus_write && bus_addr == 6'h0c) ? bus_wdata : param_ff;
		nxt_echo = cmd ? bus_wdata : echo_ff;
	end
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			param_ff <= 8'h00;
			echo_ff <= 8'h00;
		end else begin
			param_ff <= nxt_param;
			echo_ff <= nxt_echo;
		end
	end
	chk_echo_value: assert property (bus_addr == 6'h1e |=> bus_rdata == $past(echo_ff))
		else $error("echo byte differs from last command");
	chk_filter_load: assert property (cmd && bus_wdata == 8'h20 |=> filter_enable == $past(param_ff))
		else $error("filter mask not loaded");
	chk_filter_hold: assert property (!(cmd && bus_wdata == 8'h20) |=> $stable(filter_enable))
		else $error("filter mask changed without command");
	chk_a_start: assert property (cmd && bus_wdata == 8'h1f && param_ff[0] |-> ##[1:2] pulse_channel_a)
		else $error("channel a did not start");
	chk_b_start: assert property (cmd && bus_wdata == 8'h1f && param_ff[1] |-> ##[1:2] pulse_channel_b)
		else $error("channel b did not start");
	chk_a_stop: assert property (cmd && bus_wdata == 8'h1f && !param_ff[0] |-> ##2 !pulse_channel_a)
		else $error("channel a not held low");
	chk_b_stop: assert property (cmd && bus_wdata == 8'h1f && !param_ff[1] |-> ##2 !pulse_channel_b)
		else $error("channel b not held low");
	chk_unmapped_zero: assert property (!(bus_addr inside {[6'h1c:6'h1f]}) |=> bus_rdata == 8'h00)
		else $error("non-readable address returned data");
	cover property (cmd && bus_wdata == 8'h07);
	cover property ($rose(pulse_channel_a));
	cover property ($fell(pulse_channel_b));
endmodule : mpfcu_monitor

bind mpfcu_command_unit mpfcu_monitor i_monitor (.clk, .reset_n, .bus_addr, .bus_write,
	.bus_wdata, .bus_rdata, .isolated_input, .filter_enable, .pulse_channel_a, .pulse_channel_b);

/* mpfcu_host_model.sv */
`timescale 1ns/100ps
// ********************
// Host side of the mailbox
// ********************
module mpfcu_host_model (
	input wire logic clk,
	output logic [5:0] bus_addr,
	output logic bus_write,
	output logic [7:0] bus_wdata,
	input wire logic [7:0] bus_rdata
);
	initial begin
		bus_addr = 6'h00;
		bus_write = 1'b0;
		bus_wdata = 8'h00;
	end
	task automatic write_byte(input logic [5:0] addr, input logic [7:0] data);
		@(posedge clk);
		bus_addr <= addr;
		bus_write <= 1'b1;
		bus_wdata <= data;
		@(posedge clk);
		bus_write <= 1'b0;
		// Released data is inverted so a stale byte is never mistaken for valid
		bus_wdata <= ~data;
	endtask : write_byte
	task automatic read_byte(input logic [5:0] addr, output logic [7:0] data);
		@(posedge clk);
		bus_addr <= addr;
		// Read data is registered one edge after the address
		@(posedge clk);
		@(posedge clk);
		data = bus_rdata;
	endtask : read_byte
	task automatic send_cmd(input logic [15:0] param, input logic [7:0] code);
		write_byte(6'h0c, param[7:0]);
		write_byte(6'h0d, param[15:8]);
		write_byte(6'h0e, code);
	endtask : send_cmd
endmodule : mpfcu_host_model

/* tb.sv */
`timescale 1ns/100ps
// ********************
// Command unit bench
// ********************
module tb;
	logic clk;
	logic reset_n;
	logic [7:0] isolated_input;
	logic [7:0] filter_enable;
	logic [7:0] bus_rdata;
	logic [7:0] bus_wdata;
	logic [5:0] bus_addr;
	logic bus_write;
	logic pulse_channel_a;
	logic pulse_channel_b;
	logic prev_a;
	logic prev_b;
	int miscompares;
	int tests_run;
	int rises_a;
	int rises_b;
	mpfcu_command_unit #(.FIRMWARE_VERSION(16'h1234), .HARDWARE_VERSION(16'h5678)) i_dut (
		.clk, .reset_n, .bus_addr, .bus_write, .bus_wdata, .bus_rdata, .isolated_input,
		.filter_enable, .pulse_channel_a, .pulse_channel_b);
	mpfcu_host_model i_host (.clk, .bus_addr, .bus_write, .bus_wdata, .bus_rdata);
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		if (!reset_n) begin
			prev_a <= 1'b0;
			prev_b <= 1'b0;
			rises_a <= 0;
			rises_b <= 0;
		end else begin
			prev_a <= pulse_channel_a;
			prev_b <= pulse_channel_b;
			if (pulse_channel_a && !prev_a) rises_a <= rises_a + 1;
			if (pulse_channel_b && !prev_b) rises_b <= rises_b + 1;
		end
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic result(output logic [15:0] r);
		logic [7:0] hi;
		logic [7:0] lo;
		i_host.read_byte(6'h1d, hi);
		i_host.read_byte(6'h1c, lo);
		r = {hi, lo};
	endtask : result
	task automatic conclude;
		$display("Counts: %0d compares, %0d mismatches", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude
	initial begin
		repeat (100000) @(posedge clk);
		miscompares++;
		conclude();
	end
	initial begin
		logic [15:0] r;
		logic [15:0] v;
		logic [7:0] b;
		int ra;
		int rb;
		reset_n = 1'b0;
		isolated_input = 8'ha5;
		repeat (6) @(posedge clk);
		reset_n <= 1'b1;
		i_host.read_byte(6'h0c, b);
		check(b, 8'h00);
		i_host.write_byte(6'h0f, 8'h00);
		for (int i = 0; i < 2; i++) begin
			i_host.send_cmd(16'h0000, 8'h0e + 8'(i));
			result(r);
			check(r, (i == 0) ? 16'h1234 : 16'h5678);
		end
		i_host.send_cmd(16'h0011, 8'h20);
		i_host.read_byte(6'h1e, b);
		check(b, 8'h20);
		check(filter_enable, 8'h11);
		i_host.send_cmd(16'h0020, 8'h07);
		i_host.read_byte(6'h1e, b);
		check(b, 8'h07);
		result(r);
		check(r, 16'h5611);
		i_host.send_cmd(16'h00ff, 8'h20);
		result(r);
		check(r, 16'h5611);
		check(filter_enable, 8'hff);
		for (int i = 0; i < 6; i++) begin
			v = 16'h0180 + 16'(i) * 16'h0101;
			i_host.send_cmd(v, 8'h10 + 8'(i));
			i_host.send_cmd(16'h0010 + 16'(i), 8'h07);
			result(r);
			check(r, v);
			// Short values for the pulse run: A 1+1 units, burst 2; B 1+1, forever
			v = (i < 4) ? 16'h0001 : ((i == 4) ? 16'h0002 : 16'h0000);
			i_host.send_cmd(v, 8'h10 + 8'(i));
		end
		ra = rises_a;
		rb = rises_b;
		i_host.send_cmd(16'h0003, 8'h1f);
		repeat (3) @(posedge clk);
		check(pulse_channel_a, 1'b1);
		// Period is two units (10000 cycles): B rises at 0, 10000 and 20000
		repeat (25000) @(posedge clk);
		check(16'(rises_a - ra), 16'h0002);
		check(pulse_channel_a, 1'b0);
		check(16'(rises_b - rb), 16'h0003);
		i_host.send_cmd(16'h001f, 8'h07);
		result(r);
		check(r[7:0], 8'h02);
		i_host.send_cmd(16'h0000, 8'h1f);
		repeat (3) @(posedge clk);
		check(pulse_channel_b, 1'b0);
		isolated_input <= 8'h3c;
		repeat (5001) @(posedge clk);
		i_host.read_byte(6'h1f, b);
		check(b, 8'h3c);
		i_host.read_byte(6'h00, b);
		check(b, 8'h00);
		conclude();
	end
endmodule : tb
